// ==== src/cwd_cfg.svh ====
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH
// Register offsets on the AXI4-Lite bus
`define CWD_OFS_CFGWORD 4'h0
`define CWD_OFS_SETTINGS 4'h4
`define CWD_OFS_NVWORD 4'h8
// Field positions in the configuration word
`define CWD_BIT_PROT_HI 5
`define CWD_BIT_PROT_LO 4
`define CWD_BIT_RESV 11
`define CWD_BIT_UNIMP 10
`define CWD_BIT_SELF_WR 9
`define CWD_BIT_DATA_PROT 8
`define CWD_BIT_LVP 7
`define CWD_BIT_BOR 6
`define CWD_BIT_POWERUP_TIMER_N 3
`define CWD_BIT_OSC_HI 1
`define CWD_BIT_OSC_LO 0
// Field encodings
`define CWD_PROT_OFF 2'h3
`define CWD_PROT_LOW 2'h0
`define CWD_OSC_RC 2'h3
`define CWD_OSC_HS 2'h2
`define CWD_OSC_LP 2'h0
`define CWD_PROT_LIMIT 13'h07ff
// Settings register bit positions
`define CWD_SET_PROT_EN 0
`define CWD_SET_SELF_WR 1
`define CWD_SET_DATA_PROT 2
`define CWD_SET_LVP 3
`define CWD_SET_BOR 4
`define CWD_SET_POWERUP_TIMER 5
`define CWD_SET_OSC_LO 6
`define CWD_SET_OSC_HI 7
`define CWD_SET_FAULT 8
// Bus responses
`define CWD_RESP_OKAY 2'h0
`define CWD_RESP_SLVERR 2'h2
// Timing and reset values
`define CWD_FILL_LAST 2'h3
`define CWD_WORD_RST 14'h3fff
`define CWD_SET_RST 9'h025
`endif

// ==== src/cwd_pkg.sv ====
package cwd_pkg;
   typedef enum logic [1:0] {CWD_OSC_LOW_POWER, CWD_OSC_UNUSED, CWD_OSC_HIGH_SPEED,
      CWD_OSC_RC} cwd_osc_t;
   typedef enum logic {CWD_LOAD, CWD_HOLD} cwd_state_t;
endpackage

// ==== src/cwd_config_word_decoder.sv ====
`include "cwd_cfg.svh"
// What this block does
// - Bits 5-4: 11 leaves code unprotected, 00 protects 0000h-07FFh, 10 and 01 unsupported.
// - Bit 10 is unimplemented and always reads back as one.
// - Bit 9 at one allows memory-control writes to unprotected program memory; zero blocks.
// - Bit 8 at zero protects the data EEPROM, at one leaves it unprotected.
// - Bit 7 at one gives the shared port pin its low-voltage programming entry function.
// - Bit 6 at one enables brown-out reset.
// - Bits 1-0 pick RC at 11, high-speed crystal at 10, low-power crystal at 00.
// - Brown-out reset enabled forces the power-up timer on.
module cwd_config_word_decoder (
   input wire logic clk_sys, // Core clock, 125 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [13:0] nv_word, // Nonvolatile configuration word
   input wire logic [12:0] prog_wr_addr, // Program address of a self-write request
   input wire logic prog_wr_req, // Self-write request from memory control
   output logic prog_wr_allow, // Self-write request may proceed
   output logic prog_protect_hi, // Protection field high bit
   output logic prog_protect_lo, // Protection field low bit
   output logic prog_protect_active, // Program memory 0000h-07FFh protected
   output logic self_write_enable, // Self-write permitted
   output logic data_mem_protect, // Data EEPROM protected
   output logic low_volt_prog_enable, // Shared pin acts as programming entry
   output logic prog_entry_pin_function, // Shared port pin in programming-entry role
   output logic brownout_enable, // Brown-out reset enabled
   output logic powerup_timer_on, // Effective power-up timer enable
   output cwd_pkg::cwd_osc_t osc_select, // Selected oscillator
   output logic config_fault, // Unsupported protection encoding or reserved bit clear
   input wire logic [3:0] s_axi_awaddr, // AXI write address
   input wire logic s_axi_awvalid, // AXI write address valid
   output logic s_axi_awready, // AXI write address ready
   input wire logic [31:0] s_axi_wdata, // AXI write data
   input wire logic [3:0] s_axi_wstrb, // AXI write strobes
   input wire logic s_axi_wvalid, // AXI write data valid
   output logic s_axi_wready, // AXI write data ready
   output logic [1:0] s_axi_bresp, // AXI write response
   output logic s_axi_bvalid, // AXI write response valid
   input wire logic s_axi_bready, // AXI write response ready
   input wire logic [3:0] s_axi_araddr, // AXI read address
   input wire logic s_axi_arvalid, // AXI read address valid
   output logic s_axi_arready, // AXI read address ready
   output logic [31:0] s_axi_rdata, // AXI read data
   output logic [1:0] s_axi_rresp, // AXI read response
   output logic s_axi_rvalid, // AXI read response valid
   input wire logic s_axi_rready // AXI read response ready
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Internal reset leaves on a clock edge so no flop sees a runt release
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   logic rst_n;
   assign rst_n = rst_sync_reg;

   // ----------------------------------------------------------------
   // Word sampling
   // ----------------------------------------------------------------
   // The nonvolatile word comes from outside the clock domain
   logic [13:0] nv_meta_reg;
   logic [13:0] nv_sync_reg;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nv_meta_reg <= 14'h0000;
         nv_sync_reg <= 14'h0000;
      end
      else
      begin
         nv_meta_reg <= nv_word;
         nv_sync_reg <= nv_meta_reg;
      end
   end

   // Captures once after the synchroniser has filled, then holds
   cwd_pkg::cwd_state_t state_reg;
   cwd_pkg::cwd_state_t state_next;
   logic [1:0] fill_reg;
   logic [1:0] fill_next;
   logic [13:0] word_reg;
   logic [13:0] word_next;
   always_comb
   begin
      state_next = state_reg;
      fill_next = fill_reg;
      word_next = word_reg;
      unique case (state_reg)
         cwd_pkg::CWD_LOAD:
         begin
            if (fill_reg == `CWD_FILL_LAST)
            begin
               word_next = nv_sync_reg;
               word_next[`CWD_BIT_UNIMP] = 1'b1;
               state_next = cwd_pkg::CWD_HOLD;
            end
            else
            begin
               fill_next = fill_reg + 2'h1;
            end
         end
         cwd_pkg::CWD_HOLD:
         begin
            state_next = cwd_pkg::CWD_HOLD;
         end
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= cwd_pkg::CWD_LOAD;
         fill_reg <= 2'h0;
         word_reg <= `CWD_WORD_RST;
      end
      else
      begin
         state_reg <= state_next;
         fill_reg <= fill_next;
         word_reg <= word_next;
      end
   end

   // ----------------------------------------------------------------
   // Field decoding
   // ----------------------------------------------------------------
   // Codes 10 and 01 count as protected, the safe side, and raise a fault
   function automatic logic prot_is_on(input logic [1:0] code);
      return code != `CWD_PROT_OFF;
   endfunction

   function automatic logic prot_is_bad(input logic [1:0] code);
      return (code != `CWD_PROT_OFF) && (code != `CWD_PROT_LOW);
   endfunction

   function automatic logic in_low_block(input logic [12:0] a);
      return a <= `CWD_PROT_LIMIT;
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [1:0] prot_field;
   logic [1:0] osc_field;
   logic loaded;
   assign loaded = (state_reg == cwd_pkg::CWD_HOLD);
   assign prot_field = {word_reg[`CWD_BIT_PROT_HI], word_reg[`CWD_BIT_PROT_LO]};
   assign osc_field = {word_reg[`CWD_BIT_OSC_HI], word_reg[`CWD_BIT_OSC_LO]};

   logic [8:0] set_next;
   logic [8:0] set_reg;
   always_comb
   begin
      set_next = '0;
      // Unsupported protection codes are treated as protected, the safe side
      set_next[`CWD_SET_PROT_EN] = prot_is_on(prot_field);
      set_next[`CWD_SET_SELF_WR] = word_reg[`CWD_BIT_SELF_WR];
      set_next[`CWD_SET_DATA_PROT] = ~word_reg[`CWD_BIT_DATA_PROT];
      set_next[`CWD_SET_LVP] = word_reg[`CWD_BIT_LVP];
      set_next[`CWD_SET_BOR] = word_reg[`CWD_BIT_BOR];
      set_next[`CWD_SET_POWERUP_TIMER] = ~word_reg[`CWD_BIT_POWERUP_TIMER_N]
         | word_reg[`CWD_BIT_BOR];
      set_next[`CWD_SET_OSC_HI] = osc_field[1];
      set_next[`CWD_SET_OSC_LO] = osc_field[0];
      set_next[`CWD_SET_FAULT] = prot_is_bad(prot_field)
         || !word_reg[`CWD_BIT_RESV];
      if (!loaded)
      begin
         set_next = set_reg;
      end
   end
   // Safe defaults until the word is loaded: protected, no self-write, timer on
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         set_reg <= `CWD_SET_RST;
      end
      else
      begin
         set_reg <= set_next;
      end
   end

   assign prog_protect_hi = word_reg[`CWD_BIT_PROT_HI];
   assign prog_protect_lo = word_reg[`CWD_BIT_PROT_LO];
   assign prog_protect_active = set_reg[`CWD_SET_PROT_EN];
   assign self_write_enable = set_reg[`CWD_SET_SELF_WR];
   assign data_mem_protect = set_reg[`CWD_SET_DATA_PROT];
   assign low_volt_prog_enable = set_reg[`CWD_SET_LVP];
   assign prog_entry_pin_function = set_reg[`CWD_SET_LVP];
   assign brownout_enable = set_reg[`CWD_SET_BOR];
   assign powerup_timer_on = set_reg[`CWD_SET_POWERUP_TIMER];
   assign osc_select = cwd_pkg::cwd_osc_t'({set_reg[`CWD_SET_OSC_HI], set_reg[`CWD_SET_OSC_LO]});
   assign config_fault = set_reg[`CWD_SET_FAULT];

   // Self-write gate: needs permission and an address outside the protected range
   always_comb
   begin
      prog_wr_allow = 1'b0;
      if (prog_wr_req && set_reg[`CWD_SET_SELF_WR])
      begin
         prog_wr_allow = !(set_reg[`CWD_SET_PROT_EN] && in_low_block(prog_wr_addr));
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // All registers are read-only; writes are answered SLVERR
   // Ready drops while a response waits, so one of each is under way
   logic aw_got_reg;
   logic aw_got_next;
   logic w_got_reg;
   logic w_got_next;
   logic bvalid_reg;
   logic bvalid_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;

   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready = !w_got_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;

   always_comb
   begin
      aw_got_next = aw_got_reg || (s_axi_awvalid && s_axi_awready);
      w_got_next = w_got_reg || (s_axi_wvalid && s_axi_wready);
      bvalid_next = bvalid_reg;
      if (bvalid_reg && s_axi_bready)
      begin
         bvalid_next = 1'b0;
      end
      else if (aw_got_next && w_got_next && !bvalid_reg)
      begin
         bvalid_next = 1'b1;
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
      end
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && s_axi_rready)
      begin
         rvalid_next = 1'b0;
      end
      else if (s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_next = 1'b1;
         rresp_next = `CWD_RESP_OKAY;
         rdata_next = 32'h0000_0000;
         unique case (s_axi_araddr)
            `CWD_OFS_CFGWORD: rdata_next = {18'h00000, word_reg};
            `CWD_OFS_SETTINGS: rdata_next = {23'h000000, set_reg};
            `CWD_OFS_NVWORD: rdata_next = {18'h00000, nv_sync_reg};
            default: rresp_next = `CWD_RESP_SLVERR;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
      end
      else
      begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         bvalid_reg <= bvalid_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = `CWD_RESP_SLVERR;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule

// ==== tb/cwd_core_model.sv ====
module cwd_core_model (
   input wire logic clk_sys, // Clock
   input wire logic go, // Request from bench
   input wire logic [12:0] addr, // Target address
   output logic prog_wr_req, // Self-write request
   output logic [12:0] prog_wr_addr // Self-write address
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      prog_wr_req = 1'b0;
      prog_wr_addr = 13'h0000;
   end
   // Idle address toggles so a stale value never looks valid
   always @(posedge clk_sys)
   begin
      prog_wr_req <= go;
      prog_wr_addr <= go ? addr : ~prog_wr_addr;
   end
endmodule

// ==== tb/cwd_chk_properties.sv ====
module cwd_chk (
   input wire logic clk_sys, // Clock
   input wire logic rstn, // Reset
   input wire logic [12:0] prog_wr_addr, // Addr
   input wire logic prog_wr_req, // Req
   input wire logic prog_wr_allow, // Gate
   input wire logic prog_protect_hi, // Field
   input wire logic prog_protect_lo, // Field
   input wire logic prog_protect_active, // Prot
   input wire logic self_write_enable, // Self
   input wire logic low_volt_prog_enable, // Lvp
   input wire logic prog_entry_pin_function, // Pin
   input wire logic brownout_enable, // Bor
   input wire logic powerup_timer_on, // Powerup_timer
   input wire logic s_axi_arvalid, // Ar
   input wire logic s_axi_arready, // Ar
   input wire logic s_axi_rvalid, // R
   input wire logic s_axi_rready, // R
   input wire logic [31:0] s_axi_rdata, // R
   input wire logic s_axi_bvalid, // B
   input wire logic [1:0] s_axi_bresp // B
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] age_reg;
   logic [3:0] age_next;
   logic ok;
   // -----
   // Settling counter after reset
   // -----
   always_comb
   begin
      age_next = age_reg;
      if (age_reg != 4'hf)
         age_next = age_reg + 4'h1;
   end
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         age_reg <= 4'h0;
      else
         age_reg <= age_next;
   end
   assign ok = (age_reg == 4'hf);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_prot_field:
      assert property (ok |-> prog_protect_active == !(prog_protect_hi && prog_protect_lo))
      else $error("protect decode wrong");
   chk_self_wr_gate:
      assert property (ok |-> prog_wr_allow == (prog_wr_req && self_write_enable
         && !(prog_protect_active && prog_wr_addr <= 13'h07ff))) else $error("write gate wrong");
   chk_lvp_pin:
      assert property (ok |-> prog_entry_pin_function == low_volt_prog_enable)
      else $error("pin role wrong");
   chk_powerup_timer_forced:
      assert property (brownout_enable |-> powerup_timer_on) else $error("timer not forced");
   chk_hold_stable:
      assert property (ok |=> $stable({prog_protect_active, self_write_enable, brownout_enable,
         powerup_timer_on, low_volt_prog_enable})) else $error("settings moved");
   chk_write_refused:
      assert property (s_axi_bvalid |-> s_axi_bresp == 2'h2) else $error("write accepted");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no answer");
   cover property (ok && prog_wr_allow);
   cover property (s_axi_bvalid);
   cover property (ok && brownout_enable);
endmodule
bind cwd_config_word_decoder cwd_chk u_chk (.clk_sys(clk_sys), .rstn(rstn),
   .prog_wr_addr(prog_wr_addr), .prog_wr_req(prog_wr_req), .prog_wr_allow(prog_wr_allow),
   .prog_protect_hi(prog_protect_hi), .prog_protect_lo(prog_protect_lo),
   .prog_protect_active(prog_protect_active), .self_write_enable(self_write_enable),
   .low_volt_prog_enable(low_volt_prog_enable), .brownout_enable(brownout_enable),
   .prog_entry_pin_function(prog_entry_pin_function), .powerup_timer_on(powerup_timer_on),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bresp(s_axi_bresp));

// ==== tb/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rstn, go, prog_wr_req, prog_wr_allow, prog_protect_hi, prog_protect_lo;
   logic prog_protect_active, self_write_enable, data_mem_protect, low_volt_prog_enable;
   logic prog_entry_pin_function, brownout_enable, powerup_timer_on, config_fault;
   logic [13:0] nv_word;
   logic [12:0] addr, prog_wr_addr;
   cwd_pkg::cwd_osc_t osc_select;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int error_cnt = 0;
   int total_checks = 0;
   logic [13:0] words [5] = '{14'h3fff, 14'h0802, 14'h0b28, 14'h0318, 14'h0e01};
   cwd_config_word_decoder u_cwd_config_word_decoder (.clk_sys, .rstn, .nv_word, .prog_wr_addr,
      .prog_wr_req, .prog_wr_allow, .prog_protect_hi, .prog_protect_lo, .prog_protect_active,
      .self_write_enable, .data_mem_protect, .low_volt_prog_enable, .prog_entry_pin_function,
      .brownout_enable, .powerup_timer_on, .osc_select, .config_fault, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cwd_core_model u_cwd_core_model (.clk_sys, .go, .addr, .prog_wr_req, .prog_wr_addr);
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // -----
   // Helpers
   // -----
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [10:0] dec(input logic [13:0] w);
      return {w[5:4], w[5] ^ w[4] | ~w[11], w[1:0], ~w[3] | w[6], w[6], w[7], ~w[8], w[9],
         w[5:4] != 2'h3};
   endfunction
   task automatic boot(input logic [13:0] w);
      rstn <= 1'b0;
      nv_word <= w;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (14) @(posedge clk_sys);
   endtask
   task automatic rd_reg(input logic [3:0] a);
      logic ok;
      ok = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!ok)
      begin
         @(negedge clk_sys);
         ok = s_axi_arready;
         @(posedge clk_sys);
      end
      s_axi_arvalid <= 1'b0;
      ok = 1'b0;
      while (!ok)
      begin
         @(negedge clk_sys);
         ok = s_axi_rvalid;
         @(posedge clk_sys);
      end
      s_axi_rready <= 1'b1;
      @(negedge clk_sys);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wr_reg(input logic [3:0] a);
      logic ta, tw, ok;
      {ta, tw, ok} = 3'h0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge clk_sys);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         @(posedge clk_sys);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end
      while (!ok)
      begin
         @(negedge clk_sys);
         ok = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge clk_sys);
      end
   endtask
   task automatic probe(input logic [13:0] w, input logic [12:0] a);
      go <= 1'b1;
      addr <= a;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp("allow", w[9] & !(w[5:4] != 2'h3 && a <= 13'h07ff), prog_wr_allow);
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp("idle", 32'h0, prog_wr_allow);
      @(posedge clk_sys);
   endtask
   function automatic logic [10:0] outs();
      return {prog_protect_hi, prog_protect_lo, config_fault, osc_select, powerup_timer_on,
         brownout_enable, low_volt_prog_enable, data_mem_protect, self_write_enable,
         prog_protect_active};
   endfunction
   // -----
   // Scenarios
   // -----
   task automatic t_decode();
      foreach (words[i])
      begin
         boot(words[i]);
         cmp("outs", dec(words[i]), outs());
         cmp("pin", words[i][7], prog_entry_pin_function);
         rd_reg(4'h0);
         cmp("word", {18'h0, words[i] | 14'h0400}, rd);
         rd_reg(4'h4);
         cmp("settings", {23'h0, 9'(dec(words[i]))}, rd);
         probe(words[i], 13'h07ff);
         probe(words[i], 13'h0800);
      end
   endtask
   task automatic t_hold();
      boot(words[1]);
      nv_word <= words[0];
      repeat (20) @(posedge clk_sys);
      cmp("held", dec(words[1]), outs());
      rd_reg(4'h8);
      cmp("live", {18'h0, words[0]}, rd);
   endtask
   task automatic t_bus();
      wr_reg(4'h0);
      cmp("bresp", 32'h2, rs);
      rd_reg(4'h0);
      cmp("kept", {18'h0, words[1] | 14'h0400}, rd);
      cmp("rresp_ok", 32'h0, rs);
      rd_reg(4'hc);
      cmp("rresp", 32'h2, rs);
      cmp("rdata", 32'h0, rd);
   endtask
   initial
   begin
      rstn = 1'b0;
      nv_word = 14'h3fff;
      go = 1'b0;
      addr = 13'h0000;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wdata = 32'h0000ffff;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = 4'h0;
      s_axi_bready = 1'b1;
      t_decode();
      t_hold();
      t_bus();
      complete_run();
   end
   initial
   begin
      #200us;
      error_cnt++;
      complete_run();
   end
endmodule
